/* File: dv/scs_ext_osc.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External clock source or resonator
// ----------------------------------------
module scs_ext_osc #(
  parameter int HALF = 3
) (
  input wire logic core_clk,
  input wire logic run,
  output logic primary_osc_pin_in,
  output logic sec_osc_tick,
  output logic sec_osc_ready
);
  int cnt = 0;
  initial primary_osc_pin_in = 1'b0;
  initial sec_osc_tick = 1'b0;
  // stopped clock holds level
  // A halted source freezes its pin, so the device must freeze with it
  always @(posedge core_clk)
  begin
    sec_osc_tick <= 1'b0;
    if (run)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
      begin
        primary_osc_pin_in <= ~primary_osc_pin_in;
        sec_osc_tick <= primary_osc_pin_in;
      end
    end
  end
  // Secondary crystal counts as usable only while it swings
  assign sec_osc_ready = run;
endmodule : scs_ext_osc
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"
module tb_top;
  logic core_clk, rst_n, run, hf_osc_tick, lf_osc_tick, lf_periph_req, frc_req;
  logic primary_osc_pin_in, sec_osc_tick, sec_osc_ready, sys_tick, lf_periph_tick;
  logic [1:0] amp_gain, ext_power;
  logic [7:0] tc;
  scs_pkg::scs_cfg_t cfg;
  scs_pkg::scs_ctrl_t ctrl;
  scs_pkg::scs_src_t sys_src;
  scs_pkg::scs_osc_en_t osc_en;
  scs_pkg::scs_status_t st;
  scs_pkg::scs_pins_t pins;
  int err_count = 0;
  int tests_run = 0;
  int cyc_count = 0;
  int n;
  // ----------------------------------------
  // Clock, internal oscillator ticks, time limit
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // HF ticks every 2 cycles, LF every 8, so dividers are visible in short runs
  always @(posedge core_clk)
  begin
    #2;
    tc = tc + 8'h01;
    hf_osc_tick = tc[0];
    lf_osc_tick = (tc[2:0] == 3'h0);
    cyc_count++;
    if (cyc_count == 60000)
    begin
      err_count++;
      test_done();
    end
  end
  scs_ext_osc osc (.core_clk(core_clk), .run(run), .primary_osc_pin_in(primary_osc_pin_in),
    .sec_osc_tick(sec_osc_tick), .sec_osc_ready(sec_osc_ready));
  scs_clock_select #(.OST_TICKS(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .cfg_words(cfg),
    .oscillator_control_reg(ctrl), .primary_osc_pin_in(primary_osc_pin_in),
    .sec_osc_tick(sec_osc_tick), .sec_osc_ready(sec_osc_ready), .hf_osc_tick(hf_osc_tick),
    .lf_osc_tick(lf_osc_tick), .lf_periph_req(lf_periph_req), .frc_req(frc_req),
    .sys_tick(sys_tick), .sys_src(sys_src), .osc_en(osc_en), .oscillator_status_reg(st),
    .amp_gain(amp_gain), .ext_power(ext_power), .pins(pins), .lf_periph_tick(lf_periph_tick));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask : cyc
  function automatic logic pick(input int k);
    case (k)
      0: return osc_en.hf_en;
      1: return st.hf_ready_flag;
      2: return st.hf_stable_flag;
      3: return osc_en.lf_en;
      4: return st.lf_ready_flag;
      5: return osc_en.frc_en;
      6: return lf_periph_tick;
      default: return sys_tick;
    endcase
  endfunction : pick
  // Waits for a level under a bound; the count lets callers judge latency
  task wait_hi(input int k, input int lim);
    n = 0;
    while (pick(k) !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk({3'h0, pick(k)}, 4'h1);
  endtask : wait_hi
  task near(input int exp);
    chk({3'h0, n >= exp - 2 && n <= exp + 2}, 4'h1);
  endtask : near
  task wait_src(input scs_pkg::scs_src_t s);
    n = 0;
    while (sys_src !== s && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk({2'h0, sys_src}, {2'h0, s});
  endtask : wait_src
  task count_ticks(input int k);
    n = 0;
    repeat (k)
    begin
      cyc(1);
      n += (sys_tick === 1'b1);
    end
  endtask : count_ticks
  task boot(input logic [2:0] f, input logic clkout);
    rst_n = 1'b0;
    cfg = '{fosc: f, clock_output_enable_cfg: clkout};
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
  endtask : boot
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_internal_osc_mode();
    ctrl = '{clock_select_field: 2'h0, internal_freq_select: 4'hF};
    boot(3'h4, 1'b1);
    wait_hi(0, 10);
    wait_hi(1, 200);
    near(`SCS_HF_READY_CYC);
    wait_src(scs_pkg::SRC_HF);
    chk({3'h0, pins.primary_osc_pin_gpio}, 4'h1);
    chk({3'h0, pins.secondary_osc_pin_oe}, 4'h1);
    count_ticks(40);
    near(20);
    // Next step down halves the rate of the undivided oscillator
    ctrl.internal_freq_select = 4'hE;
    cyc(10);
    count_ticks(80);
    near(20);
    wait_hi(2, 5000);
    $display("test internal_osc_mode done");
  endtask : t_internal_osc_mode
  task t_lf();
    ctrl = '{clock_select_field: 2'h2, internal_freq_select: 4'h0};
    // Latency is timed from the enable, so no idle cycles before it
    wait_hi(3, 5);
    wait_hi(4, 2000);
    near(`SCS_LF_READY_CYC);
    chk({3'h0, osc_en.hf_en}, 4'h0);
    wait_src(scs_pkg::SRC_LF);
    $display("test lf done");
  endtask : t_lf
  task t_ext();
    ctrl = '{clock_select_field: 2'h0, internal_freq_select: 4'hF};
    for (int f = 0; f < 8; f++)
    begin
      if (f == 3 || f == 4)
        continue;
      boot(f[2:0], 1'b0);
      chk({2'h0, amp_gain}, f < 3 ? f[3:0] + 4'h1 : 4'h0);
      chk({2'h0, ext_power}, f > 4 ? f[3:0] - 4'h4 : 4'h0);
      chk({3'h0, osc_en.hf_en}, 4'h0);
      chk({3'h0, pins.primary_osc_pin_gpio}, 4'h0);
      chk({3'h0, pins.secondary_osc_pin_gpio}, f > 4 ? 4'h1 : 4'h0);
      // No start-up timer in external clock mode, so ticks come at once
      if (f > 4)
        wait_hi(7, 12);
    end
    $display("test ext done");
  endtask : t_ext
  task t_static_sec();
    run = 1'b0;
    count_ticks(50);
    chk(n[3:0], 4'h0);
    chk({2'h0, sys_src}, 4'h0);
    run = 1'b1;
    wait_hi(7, 12);
    ctrl.clock_select_field = 2'h1;
    wait_src(scs_pkg::SRC_SEC);
    ctrl.clock_select_field = 2'h0;
    wait_src(scs_pkg::SRC_PRI);
    frc_req = 1'b1;
    wait_hi(5, 3);
    lf_periph_req = 1'b1;
    wait_hi(3, 3);
    wait_hi(6, 20);
    $display("test static sec done");
  endtask : t_static_sec
  initial
  begin
    tc = 8'h00;
    hf_osc_tick = 1'b0;
    lf_osc_tick = 1'b0;
    run = 1'b1;
    lf_periph_req = 1'b0;
    frc_req = 1'b0;
    rst_n = 1'b0;
    cfg = '{fosc: 3'h4, clock_output_enable_cfg: 1'b1};
    ctrl = '{clock_select_field: 2'h0, internal_freq_select: 4'hF};
    t_internal_osc_mode();
    t_lf();
    t_ext();
    t_static_sec();
    test_done();
  end
endmodule : tb_top
`default_nettype wire

/* File: hdl/scs_clock_select.sv */
// Notes on behaviour
// RQ1: Software picks external or internal system clock via the clock select field.
// RQ2: Each reset takes the default source from the configuration oscillator select.
// RQ3: Select field switches to secondary oscillator or configured external source.
// RQ4: HF oscillator runs when HF frequency chosen and config is internal or select is 1x.
// RQ5: External clock mode: primary pin clocks system; secondary pin is GPIO or clock out.
// RQ6: External clock mode offers high, medium and low power settings from configuration.
// RQ7: External clock mode skips the start-up timer; no delay after reset or wake.
// RQ8: Fully static: a stopped clock freezes all state, restart resumes unchanged.
// RQ9: Resonator modes pick lowest, middle and highest amplifier gain; lowest for watch crystals.
// RQ10: Internal mode frees primary pin as GPIO; secondary pin GPIO or clock out.
// RQ11: Configuration clock output bit chooses secondary pin clock out or GPIO.
// RQ12: HF oscillator feeds a postscaler set by the four-bit frequency select.
// RQ13: Old clock keeps running until the HF oscillator has started up; here the old source stays selected but passes no ticks while waiting.
// RQ14: HF ready flag reads set whenever the HF oscillator runs.
// RQ15: HF stable flag sets once the HF oscillator is within final frequency.
// RQ16: LF oscillator runs for LF frequency with select 1x, or on peripheral request.
// RQ17: LF oscillator also clocks power-up timer, watchdog and fail-safe monitor.
// RQ18: LF ready flag reads set whenever the LF oscillator runs.
// RQ19: A separate peripheral RC clock serves mainly the converter.
// RQ20: Peripheral RC clock starts on request and keeps running in sleep.
// RQ21: Source switching produces no runt pulses or glitches on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"
module scs_clock_select #(
  parameter int OST_TICKS = `SCS_OST_TICKS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire scs_pkg::scs_cfg_t cfg_words,
  input wire scs_pkg::scs_ctrl_t oscillator_control_reg,
  input wire logic primary_osc_pin_in,
  input wire logic sec_osc_tick,
  input wire logic sec_osc_ready,
  input wire logic hf_osc_tick,
  input wire logic lf_osc_tick,
  input wire logic lf_periph_req,
  input wire logic frc_req,
  output logic sys_tick,
  output scs_pkg::scs_src_t sys_src,
  output scs_pkg::scs_osc_en_t osc_en,
  output scs_pkg::scs_status_t oscillator_status_reg,
  output logic [1:0] amp_gain,
  output logic [1:0] ext_power,
  output scs_pkg::scs_pins_t pins,
  output logic lf_periph_tick
);
  localparam int HF_READY = `SCS_HF_READY_CYC;
  localparam int HF_STABLE = `SCS_HF_STABLE_CYC;
  localparam int LF_READY = `SCS_LF_READY_CYC;

  // Counters below are 9, 12 and 16 bits wide
  generate
    if (OST_TICKS < 1 || OST_TICKS > 65535)
    begin : g_bad_ost
      $error("OST_TICKS out of range");
    end
  endgenerate

  // ----------------------------------------
  // Configuration capture and oscillator enables
  // ----------------------------------------
  scs_pkg::scs_cfg_t cfg_q, next_cfg_q;
  scs_pkg::scs_osc_en_t next_osc_en;
  logic [11:0] hf_cnt, next_hf_cnt;
  logic [11:0] lf_cnt, next_lf_cnt;
  logic lf_sel, int_cfg, scs_int;
  logic [1:0] scs;

  assign scs = oscillator_control_reg.clock_select_field;
  assign scs_int = scs[1];
  assign int_cfg = (cfg_q.fosc == `SCS_FOSC_INTERNAL_OSC_MODE);
  assign lf_sel = (oscillator_control_reg.internal_freq_select[3:1] == 3'h0);

  // Start-up counters stand in for the analog ready detectors
  always_comb
  begin
    // RQ2: reset default
    next_cfg_q = rst_n ? cfg_q : cfg_words;
    // RQ4: HF enable
    next_osc_en.hf_en = !lf_sel && (int_cfg || scs_int);
    // RQ16: LF enable
    next_osc_en.lf_en = (lf_sel && (scs_int || int_cfg)) || lf_periph_req;
    // RQ19: separate peripheral RC clock enable
    // RQ20: peripheral RC on request, not gated by sleep
    next_osc_en.frc_en = frc_req;
    next_hf_cnt = hf_cnt;
    if (!osc_en.hf_en)
      next_hf_cnt = 12'h000;
    else if (hf_cnt != 12'(HF_STABLE))
      next_hf_cnt = hf_cnt + 12'h001;
    next_lf_cnt = lf_cnt;
    if (!osc_en.lf_en)
      next_lf_cnt = 12'h000;
    else if (lf_cnt != 12'(LF_READY))
      next_lf_cnt = lf_cnt + 12'h001;
    if (!rst_n)
    begin
      next_osc_en = '0;
      next_hf_cnt = 12'h000;
      next_lf_cnt = 12'h000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    cfg_q <= next_cfg_q;
    osc_en <= next_osc_en;
    hf_cnt <= next_hf_cnt;
    lf_cnt <= next_lf_cnt;
  end

  // Status flags straight off the counters
  always_comb
  begin
    // RQ14: HF running
    oscillator_status_reg.hf_ready_flag = (hf_cnt >= 12'(HF_READY));
    // RQ15: HF within final frequency
    oscillator_status_reg.hf_stable_flag = (hf_cnt == 12'(HF_STABLE));
    // RQ18: LF running
    oscillator_status_reg.lf_ready_flag = (lf_cnt == 12'(LF_READY));
  end

  // ----------------------------------------
  // Primary pin edge and start-up timer
  // ----------------------------------------
  logic pin_q, next_pin_q;
  logic [15:0] ost_cnt, next_ost_cnt;
  logic pri_tick, xtal_mode, ec_mode, pri_ready;

  assign pri_tick = primary_osc_pin_in && !pin_q;
  assign xtal_mode = (cfg_q.fosc <= `SCS_FOSC_HS);
  assign ec_mode = (cfg_q.fosc >= `SCS_FOSC_ECL);
  // RQ7: no start-up wait outside resonator modes
  assign pri_ready = !xtal_mode || (ost_cnt == 16'(OST_TICKS));

  // Start-up timer counts resonator edges; restarts only on reset
  always_comb
  begin
    next_pin_q = rst_n ? primary_osc_pin_in : 1'b0;
    next_ost_cnt = ost_cnt;
    if (!rst_n)
      next_ost_cnt = 16'h0000;
    else if (xtal_mode && pri_tick && ost_cnt != 16'(OST_TICKS))
      next_ost_cnt = ost_cnt + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    pin_q <= next_pin_q;
    ost_cnt <= next_ost_cnt;
  end

  // ----------------------------------------
  // HF postscaler
  // ----------------------------------------
  logic [8:0] ps_cnt, next_ps_cnt;
  logic [3:0] ps_shift;
  logic [8:0] ps_mask;
  logic hf_div_tick;

  // RQ12: divide 16 MHz by a power of two from the select field
  always_comb
  begin
    ps_shift = 4'hF - oscillator_control_reg.internal_freq_select;
    if (ps_shift > `SCS_PS_MAX_SHIFT)
      ps_shift = `SCS_PS_MAX_SHIFT;
    ps_mask = 9'((10'h001 << ps_shift) - 10'h001);
    hf_div_tick = hf_osc_tick && ((ps_cnt & ps_mask) == ps_mask);
    next_ps_cnt = ps_cnt;
    if (!rst_n)
      next_ps_cnt = 9'h000;
    else if (hf_osc_tick)
      next_ps_cnt = ps_cnt + 9'h001;
  end

  always_ff @(posedge core_clk)
  begin
    ps_cnt <= next_ps_cnt;
  end

  // ----------------------------------------
  // Source switch state machine
  // ----------------------------------------
  scs_pkg::scs_state_t state, next_state;
  scs_pkg::scs_src_t next_src, tgt_src;
  logic tgt_ready, cur_tick;

  // RQ1: target source from the select field
  always_comb
  begin
    // RQ3: secondary or configured source
    if (scs_int)
      tgt_src = lf_sel ? scs_pkg::SRC_LF : scs_pkg::SRC_HF;
    else if (scs == `SCS_SEL_SEC)
      tgt_src = scs_pkg::SRC_SEC;
    else if (int_cfg)
      tgt_src = lf_sel ? scs_pkg::SRC_LF : scs_pkg::SRC_HF;
    else
      tgt_src = scs_pkg::SRC_PRI;
    case (tgt_src)
      scs_pkg::SRC_PRI: tgt_ready = pri_ready;
      scs_pkg::SRC_SEC: tgt_ready = sec_osc_ready;
      scs_pkg::SRC_HF: tgt_ready = oscillator_status_reg.hf_ready_flag;
      default: tgt_ready = oscillator_status_reg.lf_ready_flag;
    endcase
    case (sys_src)
      scs_pkg::SRC_PRI: cur_tick = pri_tick;
      scs_pkg::SRC_SEC: cur_tick = sec_osc_tick;
      scs_pkg::SRC_HF: cur_tick = hf_div_tick;
      default: cur_tick = lf_osc_tick;
    endcase
  end

  // Old source stays selected but passes no ticks while the new one starts
  always_comb
  begin
    next_state = state;
    next_src = sys_src;
    case (state)
      scs_pkg::ST_RUN:
        if (tgt_src != sys_src)
          next_state = scs_pkg::ST_WAIT;
      // RQ13: keep old source selected, ticks stopped, until ready
      scs_pkg::ST_WAIT:
        if (tgt_src == sys_src)
          next_state = scs_pkg::ST_RUN;
        else if (tgt_ready)
          next_state = scs_pkg::ST_GAP;
      // RQ21: one dead cycle, then the new source
      scs_pkg::ST_GAP:
      begin
        next_state = scs_pkg::ST_RUN;
        next_src = tgt_src;
      end
      default: next_state = scs_pkg::ST_RUN;
    endcase
    if (!rst_n)
    begin
      next_state = scs_pkg::ST_RUN;
      next_src = scs_pkg::SRC_PRI;
    end
  end

  always_ff @(posedge core_clk)
  begin
    state <= next_state;
    sys_src <= next_src;
  end

  // ----------------------------------------
  // Outputs and pin functions
  // ----------------------------------------
  logic next_sys_tick, next_lf_periph_tick, clkout_lvl, next_clkout_lvl;
  logic [1:0] next_amp_gain, next_ext_power;
  scs_pkg::scs_pins_t next_pins;

  always_comb
  begin
    // RQ8: no tick in, nothing moves; state simply waits
    next_sys_tick = (state == scs_pkg::ST_RUN) && cur_tick;
    // RQ17: LF tick to timers and monitor
    next_lf_periph_tick = osc_en.lf_en && lf_osc_tick;
    next_clkout_lvl = next_sys_tick ? !clkout_lvl : clkout_lvl;
    // RQ9: amplifier gain per resonator mode
    case (cfg_q.fosc)
      `SCS_FOSC_LP: next_amp_gain = `SCS_LVL_LOW;
      `SCS_FOSC_XT: next_amp_gain = `SCS_LVL_MED;
      `SCS_FOSC_HS: next_amp_gain = `SCS_LVL_HIGH;
      default: next_amp_gain = `SCS_LVL_OFF;
    endcase
    // RQ6: external clock power setting
    case (cfg_q.fosc)
      `SCS_FOSC_ECL: next_ext_power = `SCS_LVL_LOW;
      `SCS_FOSC_ECM: next_ext_power = `SCS_LVL_MED;
      `SCS_FOSC_ECH: next_ext_power = `SCS_LVL_HIGH;
      default: next_ext_power = `SCS_LVL_OFF;
    endcase
    // RQ5: primary pin carries the clock outside internal mode
    // RQ10: internal mode frees the primary pin
    next_pins.primary_osc_pin_gpio = int_cfg;
    // RQ11: clock out versus GPIO on the secondary pin
    next_pins.secondary_osc_pin_gpio = !xtal_mode && !cfg_q.clock_output_enable_cfg;
    next_pins.secondary_osc_pin_oe = !xtal_mode && cfg_q.clock_output_enable_cfg;
    next_pins.secondary_osc_pin_out = next_pins.secondary_osc_pin_oe && next_clkout_lvl;
    if (!rst_n)
    begin
      next_sys_tick = 1'b0;
      next_lf_periph_tick = 1'b0;
      next_clkout_lvl = 1'b0;
      next_amp_gain = `SCS_LVL_OFF;
      next_ext_power = `SCS_LVL_OFF;
      next_pins = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    sys_tick <= next_sys_tick;
    lf_periph_tick <= next_lf_periph_tick;
    clkout_lvl <= next_clkout_lvl;
    amp_gain <= next_amp_gain;
    ext_power <= next_ext_power;
    pins <= next_pins;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  hf_enable_a: assert property ($past(rst_n) |-> osc_en.hf_en == $past(!lf_sel && (int_cfg || scs_int))) // RQ4
    else $error("HF enable wrong");
  lf_enable_a: assert property ((lf_periph_req || (lf_sel && scs_int)) |=> osc_en.lf_en) // RQ16
    else $error("LF enable missing");
  reset_default_a: assert property ($rose(rst_n) |-> cfg_q == $past(cfg_words)) // RQ2
    else $error("Config not captured at reset");
  hf_ready_off_a: assert property (!osc_en.hf_en |=> !oscillator_status_reg.hf_ready_flag) // RQ14
    else $error("HF ready while off");
  hf_stable_a: assert property (oscillator_status_reg.hf_stable_flag |->
    oscillator_status_reg.hf_ready_flag && $past(osc_en.hf_en, 2)) // RQ15
    else $error("HF stable without ready");
  lf_ready_a: assert property (oscillator_status_reg.lf_ready_flag |-> $past(osc_en.lf_en)) // RQ18
    else $error("LF ready while off");
  no_runt_a: assert property ((state != scs_pkg::ST_RUN) |=> !sys_tick) // RQ21
    else $error("Tick during switch");
  ec_no_ost_a: assert property (ec_mode |-> pri_ready) // RQ7
    else $error("Start-up delay in external clock mode");
  gain_low_a: assert property ((cfg_q.fosc == `SCS_FOSC_LP) |=> amp_gain == `SCS_LVL_LOW) // RQ9
    else $error("Watch crystal gain wrong");
  int_pin_a: assert property (int_cfg |=> pins.primary_osc_pin_gpio) // RQ10
    else $error("Primary pin not freed");
  sec_switch_a: assert property ((state == scs_pkg::ST_RUN && tgt_src == scs_pkg::SRC_SEC
    && sys_src != scs_pkg::SRC_SEC && sec_osc_ready) ##1
    (tgt_src == scs_pkg::SRC_SEC && sec_osc_ready)[*2] |=> sys_src == scs_pkg::SRC_SEC) // RQ3
    else $error("Secondary switch late");
  frc_req_a: assert property (frc_req |=> osc_en.frc_en) // RQ20
    else $error("Peripheral RC not started");

  sw_hf_c: cover property (state == scs_pkg::ST_GAP && tgt_src == scs_pkg::SRC_HF);
  sw_lf_c: cover property (state == scs_pkg::ST_GAP && tgt_src == scs_pkg::SRC_LF);
  sw_pri_c: cover property (state == scs_pkg::ST_GAP && tgt_src == scs_pkg::SRC_PRI);
  hf_stable_c: cover property ($rose(oscillator_status_reg.hf_stable_flag));
endmodule : scs_clock_select
`default_nettype wire

/* File: include/scs_defs.svh */
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
// ----------------------------------------
// Configuration oscillator select codes
// ----------------------------------------
`define SCS_FOSC_LP 3'h0
`define SCS_FOSC_XT 3'h1
`define SCS_FOSC_HS 3'h2
`define SCS_FOSC_EXTERNAL_RC_MODE 3'h3
`define SCS_FOSC_INTERNAL_OSC_MODE 3'h4
`define SCS_FOSC_ECL 3'h5
`define SCS_FOSC_ECM 3'h6
`define SCS_FOSC_ECH 3'h7
// ----------------------------------------
// Clock select field codes
// ----------------------------------------
`define SCS_SEL_CFG 2'h0
`define SCS_SEL_SEC 2'h1
// ----------------------------------------
// Amplifier gain and external power codes
// ----------------------------------------
`define SCS_LVL_OFF 2'h0
`define SCS_LVL_LOW 2'h1
`define SCS_LVL_MED 2'h2
`define SCS_LVL_HIGH 2'h3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SCS_CFG_RST 4'h8
`define SCS_CORE_MHZ 40
`define SCS_HF_READY_NS 2000
`define SCS_HF_STABLE_NS 100000
`define SCS_LF_READY_NS 32000
`define SCS_HF_READY_CYC ((`SCS_HF_READY_NS * `SCS_CORE_MHZ + 999) / 1000)
`define SCS_HF_STABLE_CYC ((`SCS_HF_STABLE_NS * `SCS_CORE_MHZ + 999) / 1000)
`define SCS_LF_READY_CYC ((`SCS_LF_READY_NS * `SCS_CORE_MHZ + 999) / 1000)
`define SCS_OST_TICKS 1024
`define SCS_PS_MAX_SHIFT 4'h9
`endif

/* File: include/scs_pkg.sv */
package scs_pkg;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] fosc;
    logic clock_output_enable_cfg;
  } scs_cfg_t;
  typedef struct packed {
    logic [1:0] clock_select_field;
    logic [3:0] internal_freq_select;
  } scs_ctrl_t;
  typedef struct packed {
    logic hf_en;
    logic lf_en;
    logic frc_en;
  } scs_osc_en_t;
  typedef struct packed {
    logic hf_ready_flag;
    logic hf_stable_flag;
    logic lf_ready_flag;
  } scs_status_t;
  typedef struct packed {
    logic primary_osc_pin_gpio;
    logic secondary_osc_pin_gpio;
    logic secondary_osc_pin_oe;
    logic secondary_osc_pin_out;
  } scs_pins_t;
  typedef enum logic [1:0] {
    SRC_PRI = 2'h0,
    SRC_SEC = 2'h1,
    SRC_HF = 2'h2,
    SRC_LF = 2'h3
  } scs_src_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_WAIT = 3'h2,
    ST_GAP = 3'h4
  } scs_state_t;
endpackage : scs_pkg
